// ---- rtl/touch_irq_led.sv ----
// Behaviour
// [RULE1] Each touch raises one event at contact start and one at contact end.
// [RULE2] Host reads status on first interrupt so the line can re-assert later.
// [RULE3] Guard output copies the excitation of the sensor being measured.
// [RULE4] Pin function 01 makes the pin an interrupt trigger input.
// [RULE5] Trigger field decodes none, low, high, falling, rising, both edges.
// [RULE6] Trigger condition sets flag bit 15 of second status and asserts interrupt.
// [RULE7] Reading second status clears flag unless condition or touch event persists.
// [RULE8] Drive code times the fixed step gives the drive current.
// [RULE9] A one in the LED enable bit makes the channel an LED driver.
// [RULE10] LED enable wins over sensor connection on a dual purpose channel.
// [RULE11] Each driver holds a five bit sensor selector.
// [RULE12] Drivers follow their sensor touch without host action.
// [RULE13] Untouched gives minimum code, touched gives maximum code.
// [RULE14] Separate minimum and maximum codes per driver.
// [RULE15] Interrupt output is active low, driven low on an event.
// [RULE16] Sensor status bit reads one after touch and zero after untouch.
// [RULE17] The pin input is synchronised before level and edge detection.
`timescale 1ns/1ns
module touch_irq_led (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Register port.
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [9:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   // Touch engine.
   input  wire logic [19:0] touch_state,
   input  wire logic [19:0] measure_active,
   input  wire logic        excitation,
   // Pins.
   input  wire logic        gp_pin_in,
   output logic             guard_out,
   output logic             interrupt_out_n,
   output logic [9:0]       dual_purpose_channel,
   output logic [49:0]      led_drive_codes
);
   import touch_irq_pkg::*;

   // ------------------------------------------------------------
   // Configuration registers.
   // ------------------------------------------------------------
   logic [15:0] pin_cfg_reg, pin_cfg_next;
   logic [15:0] led_en_reg, led_en_next;
   logic [15:0] conn_lo_reg, conn_lo_next;
   logic [15:0] conn_hi_reg, conn_hi_next;
   logic [15:0] map_reg [NUM_LEDS];
   logic [15:0] map_next [NUM_LEDS];

   always_comb begin
      pin_cfg_next = pin_cfg_reg;
      led_en_next  = led_en_reg;
      conn_lo_next = conn_lo_reg;
      conn_hi_next = conn_hi_reg;
      for (int i = 0; i < NUM_LEDS; i++) begin
         map_next[i] = map_reg[i];
      end
      if (reg_wr) begin
         case (reg_addr)
            PIN_FUNCTION_CONFIG_ADDR: pin_cfg_next = reg_wdata;
            LED_CHANNEL_ENABLE_ADDR:  led_en_next  = reg_wdata;
            SENSOR_CONNECT_LOW_ADDR:  conn_lo_next = reg_wdata;
            SENSOR_CONNECT_HIGH_ADDR: conn_hi_next = reg_wdata;
            default: begin
               for (int i = 0; i < NUM_LEDS; i++) begin
                  if (reg_addr == LED_SENSOR_MAP_FIRST_ADDR + 10'(i)) begin
                     map_next[i] = reg_wdata;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_cfg_reg <= PIN_FUNCTION_CONFIG_RST;
         led_en_reg  <= ENABLE_RST;
         conn_lo_reg <= ENABLE_RST;
         conn_hi_reg <= ENABLE_RST;
         for (int i = 0; i < NUM_LEDS; i++) begin
            map_reg[i] <= LED_MAP_RST;
         end
      end else begin
         pin_cfg_reg <= pin_cfg_next;
         led_en_reg  <= led_en_next;
         conn_lo_reg <= conn_lo_next;
         conn_hi_reg <= conn_hi_next;
         for (int i = 0; i < NUM_LEDS; i++) begin
            map_reg[i] <= map_next[i];
         end
      end
   end

   // ------------------------------------------------------------
   // Pin trigger detection.
   // ------------------------------------------------------------
   logic       pin_level;
   logic       pin_prev_reg, pin_prev_next;
   logic       pin_cond;
   logic       pin_is_input;
   logic [2:0] trig_mode;

   pin_sync u_pin_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .pin_in (gp_pin_in),
      .level  (pin_level)
   ); // [RULE17]

   always_comb begin
      pin_prev_next = pin_level;
      pin_is_input  = (pin_cfg_reg[PIN_FN_LSB +: 2] == PIN_FN_INPUT); // [RULE4]
      trig_mode     = pin_cfg_reg[PIN_TRIG_LSB +: 3];
      case (trig_mode) // [RULE5]
         TRIG_LOW:  pin_cond = !pin_level;
         TRIG_HIGH: pin_cond = pin_level;
         TRIG_FALL: pin_cond = pin_prev_reg && !pin_level;
         TRIG_RISE: pin_cond = !pin_prev_reg && pin_level;
         TRIG_BOTH: pin_cond = pin_prev_reg != pin_level;
         default:   pin_cond = 1'b0;
      endcase
      pin_cond = pin_cond && pin_is_input;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev_reg <= 1'b0;
      end else begin
         pin_prev_reg <= pin_prev_next;
      end
   end

   // ------------------------------------------------------------
   // Event status and interrupt.
   // ------------------------------------------------------------
   logic [19:0] touch_prev_reg, touch_prev_next;
   logic        touch_pend_reg, touch_pend_next;
   logic        pin_flag_reg, pin_flag_next;
   logic        irq_n_reg, irq_n_next;
   logic        touch_evt;
   logic        rd_first, rd_second;

   always_comb begin
      touch_prev_next = touch_state;
      touch_evt       = (touch_state != touch_prev_reg); // [RULE1]
      rd_first        = reg_rd && (reg_addr == EVENT_FLAGS_FIRST_ADDR);
      rd_second       = reg_rd && (reg_addr == EVENT_FLAGS_SECOND_ADDR);
      touch_pend_next = touch_pend_reg;
      if (rd_first || rd_second) begin
         touch_pend_next = 1'b0;
      end
      if (touch_evt) begin
         touch_pend_next = 1'b1;
      end
      pin_flag_next = pin_flag_reg;
      if (rd_second) begin
         pin_flag_next = 1'b0; // [RULE7]
      end
      if (pin_cond) begin
         pin_flag_next = 1'b1; // [RULE6]
      end
      irq_n_next = !(pin_flag_next || touch_pend_next); // [RULE15] [RULE7]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         touch_prev_reg <= 20'h00000;
         touch_pend_reg <= 1'b0;
         pin_flag_reg   <= 1'b0;
         irq_n_reg      <= 1'b1;
      end else begin
         touch_prev_reg <= touch_prev_next;
         touch_pend_reg <= touch_pend_next;
         pin_flag_reg   <= pin_flag_next;
         irq_n_reg      <= irq_n_next;
      end
   end

   assign interrupt_out_n = irq_n_reg;

   // ------------------------------------------------------------
   // Register readback.
   // ------------------------------------------------------------
   logic [15:0] rdata_reg, rdata_next;

   always_comb begin
      rdata_next = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            PIN_FUNCTION_CONFIG_ADDR: rdata_next = pin_cfg_reg;
            LED_CHANNEL_ENABLE_ADDR:  rdata_next = led_en_reg;
            SENSOR_CONNECT_LOW_ADDR:  rdata_next = conn_lo_reg;
            SENSOR_CONNECT_HIGH_ADDR: rdata_next = conn_hi_reg;
            EVENT_FLAGS_FIRST_ADDR:   rdata_next = touch_state[15:0]; // [RULE16]
            EVENT_FLAGS_SECOND_ADDR:  rdata_next = {pin_flag_reg, 11'h000, touch_state[19:16]};
            default: begin
               for (int i = 0; i < NUM_LEDS; i++) begin
                  if (reg_addr == LED_SENSOR_MAP_FIRST_ADDR + 10'(i)) begin
                     rdata_next = map_reg[i];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ------------------------------------------------------------
   // Channel assignment, guard and LED drivers.
   // ------------------------------------------------------------
   logic [9:0] led_mode_reg, led_mode_next;
   logic       guard_reg, guard_next;

   always_comb begin
      led_mode_next = led_en_reg[9:0]; // [RULE9] [RULE10]
      guard_next    = (|measure_active) ? excitation : 1'b0; // [RULE3]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         led_mode_reg <= 10'h000;
         guard_reg    <= 1'b0;
      end else begin
         led_mode_reg <= led_mode_next;
         guard_reg    <= guard_next;
      end
   end

   assign dual_purpose_channel = led_mode_reg;
   assign guard_out            = guard_reg;

   for (genvar g = 0; g < NUM_LEDS; g++) begin : g_led
      led_channel u_led (
         .clk         (clk),
         .rst_n       (rst_n),
         .map_cfg     (map_reg[g]),
         .led_mode    (led_mode_reg[g]),
         .touch_state (touch_state),
         .drive_code  (led_drive_codes[g*CODE_W +: CODE_W])
      );
   end

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   property p_touch_irq;
      @(posedge clk) disable iff (!rst_n)
      (touch_state != touch_prev_reg) |=> !interrupt_out_n;
   endproperty
   a_touch_irq: assert property (p_touch_irq) else $error("touch event did not assert interrupt"); // [RULE1]

   property p_pin_flag;
      @(posedge clk) disable iff (!rst_n)
      pin_cond |=> pin_flag_reg && !interrupt_out_n;
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("pin trigger not flagged"); // [RULE6]

   property p_pin_clear;
      @(posedge clk) disable iff (!rst_n)
      rd_second && !pin_cond |=> !pin_flag_reg;
   endproperty
   a_pin_clear: assert property (p_pin_clear) else $error("pin flag not cleared on read"); // [RULE7]

   property p_fn_gate;
      @(posedge clk) disable iff (!rst_n)
      (pin_cfg_reg[1:0] != PIN_FN_INPUT) && !rd_second |=> pin_flag_reg == $past(pin_flag_reg);
   endproperty
   a_fn_gate: assert property (p_fn_gate) else $error("pin flag moved while pin not input"); // [RULE4]

   property p_rise;
      @(posedge clk) disable iff (!rst_n)
      pin_is_input && trig_mode == TRIG_RISE && !pin_prev_reg && pin_level |=> pin_flag_reg;
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge missed"); // [RULE5]

   property p_idle_high;
      @(posedge clk) disable iff (!rst_n)
      !pin_flag_reg && !touch_pend_reg |-> interrupt_out_n;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("interrupt low without cause"); // [RULE15]

   property p_led_mode;
      @(posedge clk) disable iff (!rst_n)
      led_en_reg[0] |=> dual_purpose_channel[0];
   endproperty
   a_led_mode: assert property (p_led_mode) else $error("LED enable did not take channel"); // [RULE10]

   property p_led_code;
      @(posedge clk) disable iff (!rst_n)
      dual_purpose_channel[0] && (int'(map_reg[0][4:0]) < NUM_SENSORS) && touch_state[map_reg[0][4:0]]
      ##1 $stable(map_reg[0]) |-> led_drive_codes[4:0] == map_reg[0][14:10];
   endproperty
   a_led_code: assert property (p_led_code) else $error("touched LED not at maximum"); // [RULE13]
endmodule

// ---- rtl/touch_irq_pkg.sv ----
package touch_irq_pkg;

   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [9:0]  PIN_FUNCTION_CONFIG_ADDR  = 10'h009;
   localparam logic [9:0]  LED_SENSOR_MAP_FIRST_ADDR = 10'h020;
   localparam logic [9:0]  LED_SENSOR_MAP_LAST_ADDR  = 10'h029;
   localparam logic [9:0]  LED_CHANNEL_ENABLE_ADDR   = 10'h03f;
   localparam logic [9:0]  SENSOR_CONNECT_LOW_ADDR   = 10'h041;
   localparam logic [9:0]  SENSOR_CONNECT_HIGH_ADDR  = 10'h042;
   localparam logic [9:0]  EVENT_FLAGS_FIRST_ADDR    = 10'h045;
   localparam logic [9:0]  EVENT_FLAGS_SECOND_ADDR   = 10'h046;

   localparam int          NUM_SENSORS    = 20;
   localparam int          NUM_LEDS       = 10;
   localparam int          LED_CHAN_BASE  = 10;
   localparam int          CODE_W         = 5;

   localparam logic [1:0]  PIN_FN_INPUT   = 2'h1;
   localparam int          PIN_FN_LSB     = 0;
   localparam int          PIN_TRIG_LSB   = 2;
   localparam int          PIN_FLAG_BIT   = 15;
   localparam int          MAP_SEL_LSB    = 0;
   localparam int          MAP_MIN_LSB    = 5;
   localparam int          MAP_MAX_LSB    = 10;

   localparam logic [15:0] PIN_FUNCTION_CONFIG_RST = 16'h0000;
   localparam logic [15:0] LED_MAP_RST             = 16'h0000;
   localparam logic [15:0] ENABLE_RST              = 16'h0000;

   // ------------------------------------------------------------
   // Pin trigger modes
   // ------------------------------------------------------------
   localparam logic [2:0]  TRIG_NONE    = 3'h0;
   localparam logic [2:0]  TRIG_LOW     = 3'h1;
   localparam logic [2:0]  TRIG_HIGH    = 3'h2;
   localparam logic [2:0]  TRIG_FALL    = 3'h5;
   localparam logic [2:0]  TRIG_RISE    = 3'h6;
   localparam logic [2:0]  TRIG_BOTH    = 3'h7;

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ns
module pin_sync (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Pin and result.
   input  wire logic pin_in,
   output logic      level
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic       level_reg;
   logic       level_next;

   // ------------------------------------------------------------
   // Three stages; a change counts when stages two and three agree.
   // ------------------------------------------------------------
   always_comb begin
      sync_next  = {sync_reg[1:0], pin_in};
      level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : level_reg;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg  <= 3'h0;
         level_reg <= 1'b0;
      end else begin
         sync_reg  <= sync_next;
         level_reg <= level_next;
      end
   end

   assign level = level_reg;
endmodule

// ---- rtl/led_channel.sv ----
`timescale 1ns/1ns
module led_channel (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Configuration.
   input  wire logic [15:0] map_cfg,
   input  wire logic       led_mode,
   input  wire logic [19:0] touch_state,
   // Drive code.
   output logic [4:0]      drive_code
);
   import touch_irq_pkg::*;
   logic [4:0] sel;
   logic [4:0] min_code;
   logic [4:0] max_code;
   logic [4:0] code_reg;
   logic [4:0] code_next;
   logic       touched;

   // ------------------------------------------------------------
   // Current code selection.
   // ------------------------------------------------------------
   always_comb begin
      sel       = map_cfg[MAP_SEL_LSB +: CODE_W]; // [RULE11]
      min_code  = map_cfg[MAP_MIN_LSB +: CODE_W]; // [RULE14]
      max_code  = map_cfg[MAP_MAX_LSB +: CODE_W]; // [RULE14]
      touched   = (int'(sel) < NUM_SENSORS) ? touch_state[sel] : 1'b0;
      code_next = 5'h00;
      if (led_mode) begin
         code_next = touched ? max_code : min_code; // [RULE12] [RULE13] [RULE8]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_reg <= 5'h00;
      end else begin
         code_reg <= code_next;
      end
   end

   assign drive_code = code_reg;
endmodule

// ---- verification/host_model.sv ----
`timescale 1ns/1ns
module host_model (
   // Clock.
   input  wire logic        clk,
   // Register port.
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [9:0]       reg_addr,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   // ------------------------------------------------------------
   // Register access
   // ------------------------------------------------------------
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 10'h3ff;
      reg_wdata = 16'hffff;
   end

   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask

   // Reading status releases the interrupt so it can fire again.
   task automatic rd(input logic [9:0] a, output logic [15:0] d);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
   import touch_irq_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk;
   logic        rst_n;
   logic        reg_wr;
   logic        reg_rd;
   logic [9:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic [19:0] touch_state;
   logic [19:0] measure_active;
   logic        excitation;
   logic        gp_pin_in;
   logic        guard_out;
   logic        interrupt_out_n;
   logic [9:0]  dual_purpose_channel;
   logic [49:0] led_drive_codes;
   int          n_fail;
   int          checks;
   logic [1:0]  fn;
   logic [2:0]  trig;
   logic        ex;

   // Modes whose flag is up once the pin has settled low, and once it has settled high again.
   localparam logic [7:0] LOW_GOING_FLAGS  = 8'ha6;
   localparam logic [7:0] HIGH_GOING_FLAGS = 8'hc6;

   initial clk = 1'b0;
   always #25 clk = ~clk;

   touch_irq_led touch_irq_led_i (
      .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .touch_state(touch_state),
      .measure_active(measure_active), .excitation(excitation), .gp_pin_in(gp_pin_in),
      .guard_out(guard_out), .interrupt_out_n(interrupt_out_n),
      .dual_purpose_channel(dual_purpose_channel), .led_drive_codes(led_drive_codes)
   );

   host_model host_model_i (
      .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
      logic [15:0] v;
      host_model_i.rd(a, v);
      chk(v, exp);
   endtask

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      #1000000;
      n_fail++;
      $display("watchdog expired at %0t", $time);
      end_sim();
   end

   initial begin
      n_fail = 0;
      checks = 0;
      rst_n = 1'b0;
      touch_state = 20'h00000;
      measure_active = 20'h00000;
      excitation = 1'b0;
      gp_pin_in = 1'b1;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;

      chk({15'h0, interrupt_out_n}, 16'h0001);
      rd_chk(PIN_FUNCTION_CONFIG_ADDR, 16'h0000);
      rd_chk(LED_CHANNEL_ENABLE_ADDR, 16'h0000);
      rd_chk(LED_SENSOR_MAP_FIRST_ADDR, 16'h0000);
      host_model_i.wr(EVENT_FLAGS_SECOND_ADDR, 16'hffff);
      rd_chk(EVENT_FLAGS_SECOND_ADDR, 16'h0000);
      host_model_i.wr(10'h3ff, 16'hffff);
      rd_chk(10'h3ff, 16'h0000);
      $display("test registers done");

      touch_state = 20'h00008;
      cyc(3);
      chk({15'h0, interrupt_out_n}, 16'h0000);
      rd_chk(EVENT_FLAGS_FIRST_ADDR, 16'h0008);
      cyc(2);
      chk({15'h0, interrupt_out_n}, 16'h0001);
      touch_state = 20'h00000;
      cyc(3);
      chk({15'h0, interrupt_out_n}, 16'h0000);
      rd_chk(EVENT_FLAGS_FIRST_ADDR, 16'h0000);
      cyc(2);
      chk({15'h0, interrupt_out_n}, 16'h0001);
      $display("test touch done");

      for (int k = 0; k < 9; k++) begin
         fn = (k < 8) ? 2'h1 : 2'h0;
         trig = (k < 8) ? k[2:0] : 3'h7;
         gp_pin_in = 1'b1;
         host_model_i.wr(PIN_FUNCTION_CONFIG_ADDR, {11'h0, trig, fn});
         cyc(6);
         rd_chk(PIN_FUNCTION_CONFIG_ADDR, {11'h0, trig, fn});
         // The high-level flag of the pass before stays pending until this read.
         rd_chk(EVENT_FLAGS_SECOND_ADDR, {(fn == 2'h1 && trig == TRIG_HIGH) || k == 3, 15'h0});
         rd_chk(EVENT_FLAGS_SECOND_ADDR, 16'h0000 | {fn == 2'h1 && trig == TRIG_HIGH, 15'h0});
         cyc(6);
         rd_chk(EVENT_FLAGS_SECOND_ADDR, {fn == 2'h1 && trig == TRIG_HIGH, 15'h0});
         gp_pin_in = 1'b0;
         cyc(6);
         ex = fn == 2'h1 && LOW_GOING_FLAGS[trig];
         chk({15'h0, interrupt_out_n}, {15'h0, !ex});
         rd_chk(EVENT_FLAGS_SECOND_ADDR, {ex, 15'h0});
         gp_pin_in = 1'b1;
         cyc(1);
         gp_pin_in = 1'b0;
         cyc(6);
         rd_chk(EVENT_FLAGS_SECOND_ADDR, {fn == 2'h1 && trig == TRIG_LOW, 15'h0});
         gp_pin_in = 1'b1;
         cyc(6);
         rd_chk(EVENT_FLAGS_SECOND_ADDR, {fn == 2'h1 && HIGH_GOING_FLAGS[trig], 15'h0});
      end
      host_model_i.wr(PIN_FUNCTION_CONFIG_ADDR, 16'h0000);
      cyc(6);
      rd_chk(EVENT_FLAGS_SECOND_ADDR, 16'h0000);
      cyc(2);
      chk({15'h0, interrupt_out_n}, 16'h0001);
      $display("test pin trigger done");

      measure_active = 20'h00010;
      for (int i = 0; i < 4; i++) begin
         excitation = i[0];
         cyc(1);
         chk({15'h0, guard_out}, {15'h0, excitation});
      end
      measure_active = 20'h00000;
      excitation = 1'b1;
      cyc(2);
      chk({15'h0, guard_out}, 16'h0000);
      $display("test guard done");

      host_model_i.wr(SENSOR_CONNECT_LOW_ADDR, 16'hffff);
      host_model_i.wr(SENSOR_CONNECT_HIGH_ADDR, 16'hffff);
      host_model_i.wr(LED_CHANNEL_ENABLE_ADDR, 16'h0201);
      cyc(2);
      chk({6'h0, dual_purpose_channel}, 16'h0201);
      rd_chk(SENSOR_CONNECT_LOW_ADDR, 16'hffff);
      rd_chk(SENSOR_CONNECT_HIGH_ADDR, 16'hffff);
      host_model_i.wr(LED_SENSOR_MAP_FIRST_ADDR, 16'h7c65);
      host_model_i.wr(LED_SENSOR_MAP_LAST_ADDR, 16'h0413);
      cyc(2);
      chk({11'h0, led_drive_codes[4:0]}, 16'h0003);
      chk({11'h0, led_drive_codes[49:45]}, 16'h0000);
      touch_state = 20'h80020;
      cyc(3);
      chk({11'h0, led_drive_codes[4:0]}, 16'h001f);
      chk({11'h0, led_drive_codes[49:45]}, 16'h0001);
      rd_chk(LED_SENSOR_MAP_LAST_ADDR, 16'h0413);
      rd_chk(EVENT_FLAGS_SECOND_ADDR, 16'h0008);
      $display("test led done");
      end_sim();
   end
endmodule
